// ===== shared/rddr_consts.vh
/*
 * Register offsets, write masks and reset values for the second reference
 * divider and reference delay register bank.
 * Assumes the serial control port decodes frames into byte-wide accesses.
 */
// What this block does
// R1: bit 7 of the control register chooses division by the four select pins (0) or by the register words (1).
// R2: bit 6 of the control register set limits the modulator to integer-only division, clear allows fractional.
// R3: bit 5 of the control register clear holds the modulator in reset with clocks stopped, set lets it run.
// R4: bit 4 of the control register at 0 powers down the first reference receiver only while the outside enable bit is 1.
// R5: the fraction word is 20-bit two's complement with a reset value of 262144.
// R6: the fraction word is bits 19..12 from 0x27, 11..4 from 0x28 and 3..0 from 0x29 bits 7..4.
// R7: the integer divide value is bits 7..2 of 0x2A and resets to 8.
// R8: software writes 0 to bit 7 of 0x2B whenever it programs that register, though it resets to 1.
// R9: the 19-bit modulus is 0x2B bits 6..0, 0x2C and 0x2D bits 7..4, resetting to zero.
// R10: bit 7 of first_ref_delay_high at 0 lets the device pick the first reference delay, at 1 the programmed word is used.
// R11: the first reference delay word is first_ref_delay_high bits 6..0 then first_ref_delay_low bits 7..6, resetting to 0x100.
// R12: bit 7 of second_ref_delay_high at 0 lets the device pick the second reference delay, at 1 the programmed word is used.
// R13: the second reference delay word is second_ref_delay_high bits 6..0 then second_ref_delay_low bits 7..6, resetting to 0x100.
// R14: unused bit positions read as zero and ignore writes.
`ifndef RDDR_CONSTS_VH
`define RDDR_CONSTS_VH

// ----------------------------------------------------------------------
// offsets
// ----------------------------------------------------------------------
`define RDDR_OFS_CTRL     8'h26
`define RDDR_OFS_FRAC_HI  8'h27
`define RDDR_OFS_FRAC_MID 8'h28
`define RDDR_OFS_FRAC_LO  8'h29
`define RDDR_OFS_INT      8'h2A
`define RDDR_OFS_MOD_HI   8'h2B
`define RDDR_OFS_MOD_MID  8'h2C
`define RDDR_OFS_MOD_LO   8'h2D
`define RDDR_OFS_DLY1_HI  8'h2E
`define RDDR_OFS_DLY1_LO  8'h2F
`define RDDR_OFS_DLY2_HI  8'h30
`define RDDR_OFS_DLY2_LO  8'h31
`define RDDR_NUM_REGS     12

// ----------------------------------------------------------------------
// control register fields and the delay override bit
// ----------------------------------------------------------------------
`define RDDR_CTRL_REG_DIV  7
`define RDDR_CTRL_INT_ONLY 6
`define RDDR_CTRL_SDM_RUN  5
`define RDDR_CTRL_RX1_ON   4
`define RDDR_DLY_OVR       7

// ----------------------------------------------------------------------
// writable bit masks
// ----------------------------------------------------------------------
`define RDDR_MSK_CTRL     8'hF0
`define RDDR_MSK_FULL     8'hFF
`define RDDR_MSK_NIBBLE   8'hF0
`define RDDR_MSK_INT      8'hFC
`define RDDR_MSK_DLY_LO   8'hC0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RDDR_RST_CTRL     8'h30
`define RDDR_RST_FRAC_HI  8'h40
`define RDDR_RST_FRAC_MID 8'h00
`define RDDR_RST_FRAC_LO  8'h00
`define RDDR_RST_INT      8'h20
`define RDDR_RST_MOD_HI   8'h80
`define RDDR_RST_MOD_MID  8'h00
`define RDDR_RST_MOD_LO   8'h00
`define RDDR_RST_DLY_HI   8'h40
`define RDDR_RST_DLY_LO   8'h00

`endif

// ===== src/rddr_regs.v
/*
 * Register bank for the second reference fractional divider and the
 * programmable delays of both references, plus the derived control outputs.
 * Assumes the serial control port hands over byte accesses, one strobe each.
 */
`timescale 1ns/1ps
`include "rddr_consts.vh"

module rddr_regs #(
    parameter SEL_W = 4
) (
    mclk,
    sys_rst,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata,
    reg_hit,
    second_ref_sel_pins,
    first_ref_rx_pd_ena,
    div_use_regs,
    div_pin_sel,
    sdm_int_only,
    sdm_reset,
    first_ref_rx_pd,
    second_ref_fraction,
    second_ref_integer_divide,
    second_ref_modulus,
    first_ref_dly_ovr,
    first_ref_dly,
    second_ref_dly_ovr,
    second_ref_dly
);
    input  wire             mclk;
    input  wire             sys_rst;
    input  wire [7:0]       reg_addr;
    input  wire [7:0]       reg_wdata;
    input  wire             reg_wr;
    input  wire             reg_rd;
    output reg  [7:0]       reg_rdata;
    output wire             reg_hit;
    input  wire [SEL_W-1:0] second_ref_sel_pins;
    input  wire             first_ref_rx_pd_ena;
    output wire             div_use_regs;
    output wire [SEL_W-1:0] div_pin_sel;
    output wire             sdm_int_only;
    output wire             sdm_reset;
    output wire             first_ref_rx_pd;
    output wire [19:0]      second_ref_fraction;
    output wire [5:0]       second_ref_integer_divide;
    output wire [18:0]      second_ref_modulus;
    output wire             first_ref_dly_ovr;
    output wire [8:0]       first_ref_dly;
    output wire             second_ref_dly_ovr;
    output wire [8:0]       second_ref_dly;

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------
    function [7:0] rddr_mask;
        input [7:0] ofs;
        begin
            case (ofs)
                `RDDR_OFS_CTRL:     rddr_mask = `RDDR_MSK_CTRL;
                `RDDR_OFS_FRAC_HI:  rddr_mask = `RDDR_MSK_FULL;
                `RDDR_OFS_FRAC_MID: rddr_mask = `RDDR_MSK_FULL;
                `RDDR_OFS_FRAC_LO:  rddr_mask = `RDDR_MSK_NIBBLE;
                `RDDR_OFS_INT:      rddr_mask = `RDDR_MSK_INT;
                `RDDR_OFS_MOD_HI:   rddr_mask = `RDDR_MSK_FULL;
                `RDDR_OFS_MOD_MID:  rddr_mask = `RDDR_MSK_FULL;
                `RDDR_OFS_MOD_LO:   rddr_mask = `RDDR_MSK_NIBBLE;
                `RDDR_OFS_DLY1_HI:  rddr_mask = `RDDR_MSK_FULL;
                `RDDR_OFS_DLY1_LO:  rddr_mask = `RDDR_MSK_DLY_LO;
                `RDDR_OFS_DLY2_HI:  rddr_mask = `RDDR_MSK_FULL;
                `RDDR_OFS_DLY2_LO:  rddr_mask = `RDDR_MSK_DLY_LO;
                default:            rddr_mask = 8'h00;
            endcase
        end
    endfunction

    function [7:0] rddr_reset;
        input [7:0] ofs;
        begin
            case (ofs)
                `RDDR_OFS_CTRL:     rddr_reset = `RDDR_RST_CTRL;
                `RDDR_OFS_FRAC_HI:  rddr_reset = `RDDR_RST_FRAC_HI;
                `RDDR_OFS_FRAC_MID: rddr_reset = `RDDR_RST_FRAC_MID;
                `RDDR_OFS_FRAC_LO:  rddr_reset = `RDDR_RST_FRAC_LO;
                `RDDR_OFS_INT:      rddr_reset = `RDDR_RST_INT;
                `RDDR_OFS_MOD_HI:   rddr_reset = `RDDR_RST_MOD_HI;
                `RDDR_OFS_MOD_MID:  rddr_reset = `RDDR_RST_MOD_MID;
                `RDDR_OFS_MOD_LO:   rddr_reset = `RDDR_RST_MOD_LO;
                `RDDR_OFS_DLY1_HI:  rddr_reset = `RDDR_RST_DLY_HI;
                `RDDR_OFS_DLY1_LO:  rddr_reset = `RDDR_RST_DLY_LO;
                `RDDR_OFS_DLY2_HI:  rddr_reset = `RDDR_RST_DLY_HI;
                `RDDR_OFS_DLY2_LO:  rddr_reset = `RDDR_RST_DLY_LO;
                default:            rddr_reset = 8'h00;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    wire [7:0] bank_r [0:`RDDR_NUM_REGS-1];
    wire [7:0] rd_mask;

    assign rd_mask = rddr_mask(reg_addr);
    assign reg_hit = (rd_mask != 8'h00);

    genvar gi;
    generate
        for (gi = 0; gi < `RDDR_NUM_REGS; gi = gi + 1) begin : g_reg
            localparam integer OFS_I = `RDDR_OFS_CTRL + gi;
            localparam [7:0]   OFS   = OFS_I[7:0];
            localparam [7:0] MSK = rddr_mask(OFS);
            localparam [7:0] RST = rddr_reset(OFS);
            reg [7:0] val_r;
            always @(posedge mclk) begin
                if (sys_rst) begin
                    val_r <= RST;
                end else if (reg_wr && (reg_addr == OFS)) begin
                    val_r <= reg_wdata & MSK; // R14
                end
            end
            assign bank_r[gi] = val_r;
        end
    endgenerate

    // ------------------------------------------------------------------
    // read back
    // ------------------------------------------------------------------
    wire [7:0] rd_idx;
    assign rd_idx = reg_addr - `RDDR_OFS_CTRL;

    always @(posedge mclk) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (reg_hit) begin
                reg_rdata <= bank_r[rd_idx[3:0]] & rd_mask; // R14
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end

    // ------------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------------
    wire [7:0] ctrl;
    assign ctrl = bank_r[0];

    assign div_use_regs    = ctrl[`RDDR_CTRL_REG_DIV]; // R1
    assign div_pin_sel     = second_ref_sel_pins; // R1
    assign sdm_int_only    = ctrl[`RDDR_CTRL_INT_ONLY]; // R2
    assign sdm_reset       = ~ctrl[`RDDR_CTRL_SDM_RUN]; // R3
    assign first_ref_rx_pd = first_ref_rx_pd_ena & ~ctrl[`RDDR_CTRL_RX1_ON]; // R4

    // ------------------------------------------------------------------
    // divider words
    // ------------------------------------------------------------------
    assign second_ref_fraction = {bank_r[1], bank_r[2], bank_r[3][7:4]}; // R5 R6
    assign second_ref_integer_divide = bank_r[4][7:2]; // R7
    assign second_ref_modulus = {bank_r[5][6:0], bank_r[6], bank_r[7][7:4]}; // R9

    // ------------------------------------------------------------------
    // delay words
    // ------------------------------------------------------------------
    assign first_ref_dly_ovr  = bank_r[8][`RDDR_DLY_OVR]; // R10
    assign first_ref_dly      = {bank_r[8][6:0], bank_r[9][7:6]}; // R11
    assign second_ref_dly_ovr = bank_r[10][`RDDR_DLY_OVR]; // R12
    assign second_ref_dly     = {bank_r[10][6:0], bank_r[11][7:6]}; // R13

endmodule

// ===== verif/rddr_asserts.sv
/* checker on the ports of rddr_regs.
   assumes it is bound to every rddr_regs instance. */
`timescale 1ns/1ps
module rddr_asserts #(parameter SEL_W = 4) (
    input wire             mclk,
    input wire             sys_rst,
    input wire [7:0]       reg_addr,
    input wire [7:0]       reg_wdata,
    input wire             reg_wr,
    input wire             reg_rd,
    input wire [7:0]       reg_rdata,
    input wire             reg_hit,
    input wire             div_use_regs,
    input wire             sdm_int_only,
    input wire             sdm_reset,
    input wire [SEL_W-1:0] second_ref_sel_pins,
    input wire [SEL_W-1:0] div_pin_sel,
    input wire             first_ref_rx_pd_ena,
    input wire             first_ref_rx_pd,
    input wire [19:0]      second_ref_fraction,
    input wire [5:0]       second_ref_integer_divide,
    input wire [18:0]      second_ref_modulus,
    input wire             first_ref_dly_ovr,
    input wire [8:0]       first_ref_dly,
    input wire             second_ref_dly_ovr,
    input wire [8:0]       second_ref_dly
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    a_reset_vals: assert property ($fell(sys_rst) |-> second_ref_fraction == 20'h40000
        && second_ref_integer_divide == 6'h08 && first_ref_dly == 9'h100) else $error("bad reset");
    a_unmapped_read: assert property (reg_rd && !reg_hit |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_pins_pass: assert property (div_pin_sel == second_ref_sel_pins)
        else $error("select pins not passed");
    a_rxpd_gated: assert property (!first_ref_rx_pd_ena |-> !first_ref_rx_pd)
        else $error("receiver down while gate off");
    a_frac_high: assert property (reg_wr && reg_addr == 8'h27 |=>
        second_ref_fraction[19:12] == $past(reg_wdata)) else $error("fraction high");
    a_int_write: assert property (reg_wr && reg_addr == 8'h2A |=>
        second_ref_integer_divide == $past(reg_wdata[7:2])) else $error("integer word");
    a_mod_high: assert property (reg_wr && reg_addr == 8'h2B |=>
        second_ref_modulus[18:12] == $past(reg_wdata[6:0])) else $error("modulus high");
    a_dly1_high: assert property (reg_wr && reg_addr == 8'h2E |=>
        {first_ref_dly_ovr, first_ref_dly[8:2]} == $past(reg_wdata)) else $error("delay one");
    a_dly2_low: assert property (reg_wr && reg_addr == 8'h31 |=>
        second_ref_dly[1:0] == $past(reg_wdata[7:6])) else $error("delay two low");
    a_ctrl_write: assert property (reg_wr && reg_addr == 8'h26 |=>
        {div_use_regs, sdm_int_only, sdm_reset} == ($past(reg_wdata[7:5]) ^ 3'b001))
        else $error("control fields");
    a_dly2_ovr: assert property (reg_wr && reg_addr == 8'h30 |=>
        second_ref_dly_ovr == $past(reg_wdata[7])) else $error("delay two override");
    a_unused_read: assert property (reg_rd && reg_addr == 8'h2F |=>
        reg_rdata[5:0] == 6'h00) else $error("unused bits not zero");
    cover property (reg_wr && reg_addr == 8'h2A);
    cover property ($fell(sys_rst));
    cover property (reg_rd && !reg_hit);
    cover property (first_ref_rx_pd);
endmodule
bind rddr_regs rddr_asserts #(.SEL_W(SEL_W)) u_chk (.*);

// ===== verif/tb.sv
/* self-checking bench for rddr_regs over its byte register port.
   assumes the checker binds itself to uut. */
`timescale 1ns/1ps
module tb;
    reg        mclk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    reg  [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
    reg  [3:0] second_ref_sel_pins = 4'h5;
    reg        first_ref_rx_pd_ena = 1'b0;
    wire [7:0] reg_rdata;
    wire [3:0] div_pin_sel;
    wire       reg_hit, div_use_regs, sdm_int_only, sdm_reset, first_ref_rx_pd;
    wire       first_ref_dly_ovr, second_ref_dly_ovr;
    wire [19:0] second_ref_fraction;
    wire [5:0] second_ref_integer_divide;
    wire [18:0] second_ref_modulus;
    wire [8:0] first_ref_dly, second_ref_dly;
    integer    fail_count = 0, samples_checked = 0;
    rddr_regs uut (.*);
    always #10 mclk = ~mclk;
    task chk(input [19:0] got, input [19:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("wrong value at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    task acc(input [7:0] a, input [7:0] d, input w);
        begin
            @(posedge mclk);
            #1;
            reg_addr = a;
            reg_wdata = d;
            reg_wr = w;
            reg_rd = !w;
            @(posedge mclk);
            #1;
            reg_wr = 1'b0;
            reg_rd = 1'b0;
            if (!w) chk(reg_rdata, d);
        end
    endtask
    task t_ctrl;
        begin
            acc(8'h26, 8'h30, 0);
            acc(8'h2B, 8'h80, 0);
            chk({first_ref_dly_ovr, first_ref_dly, second_ref_dly_ovr, second_ref_dly}, 20'h40100);
            chk(second_ref_modulus, 20'h0);
            chk({div_use_regs, sdm_int_only, sdm_reset, first_ref_rx_pd}, 20'h0);
            first_ref_rx_pd_ena = 1'b1;
            acc(8'h26, 8'hFF, 1);
            acc(8'h26, 8'hF0, 0);
            chk(reg_hit, 20'h1);
            chk({div_use_regs, sdm_int_only, sdm_reset, first_ref_rx_pd}, 20'hC);
            acc(8'h26, 8'h0F, 1);
            chk({div_use_regs, sdm_int_only, sdm_reset, first_ref_rx_pd}, 20'h3);
            first_ref_rx_pd_ena = 1'b0;
            second_ref_sel_pins = 4'hA;
            @(posedge mclk);
            #1;
            chk({first_ref_rx_pd, div_pin_sel}, 20'hA);
            $display("control test done");
        end
    endtask
    task t_words;
        begin
            acc(8'h27, 8'h81, 1);
            acc(8'h28, 8'h23, 1);
            acc(8'h29, 8'h4F, 1);
            acc(8'h2A, 8'hFF, 1);
            acc(8'h2B, 8'h7F, 1);
            acc(8'h2C, 8'hA5, 1);
            acc(8'h2D, 8'hC3, 1);
            acc(8'h2E, 8'hD5, 1);
            acc(8'h2F, 8'hFF, 1);
            acc(8'h30, 8'h2A, 1);
            acc(8'h31, 8'h7F, 1);
            chk(second_ref_fraction, 20'h81234);
            chk(second_ref_integer_divide, 20'h3F);
            chk(second_ref_modulus, 20'h7FA5C);
            chk({first_ref_dly_ovr, first_ref_dly}, 20'h357);
            chk({second_ref_dly_ovr, second_ref_dly}, 20'h0A9);
            acc(8'h29, 8'h40, 0);
            acc(8'h2A, 8'hFC, 0);
            acc(8'h2D, 8'hC0, 0);
            acc(8'h2F, 8'hC0, 0);
            acc(8'h31, 8'h40, 0);
            acc(8'h32, 8'h00, 0);
            chk(reg_hit, 20'h0);
            $display("word test done");
        end
    endtask
    task t_reset;
        begin
            chk(second_ref_fraction, 20'h40000);
            chk(second_ref_integer_divide, 20'h08);
            $display("reset test done");
        end
    endtask
    task t_rerun;
        begin
            @(posedge mclk);
            #1;
            sys_rst = 1'b1;
            @(posedge mclk);
            #1;
            sys_rst = 1'b0;
            chk(second_ref_fraction, 20'h40000);
            chk(second_ref_integer_divide, 20'h08);
            chk(second_ref_modulus, 20'h0);
            chk({first_ref_dly_ovr, first_ref_dly, second_ref_dly_ovr, second_ref_dly}, 20'h40100);
            acc(8'h2B, 8'h80, 0);
            acc(8'h2A, 8'h20, 0);
            $display("mid-run reset test done");
        end
    endtask
    task test_done;
        begin
            $display("compared %0d, mismatched %0d", samples_checked, fail_count);
            if (fail_count == 0 && samples_checked > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        #1 sys_rst = 1'b0;
        t_reset;
        t_ctrl;
        t_words;
        t_rerun;
        test_done;
    end
    initial begin
        #20000;
        fail_count = fail_count + 1;
        test_done;
    end
endmodule
